// ### src/ltm_pkg.sv
// constants and types for the loop test mode controller
// assumes a single 125 MHz system clock
package ltm_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // timing figures in their own units
  localparam int unsigned MODE_TIME_S = 75;
  localparam int unsigned GAP_TIME_MS = 500;
  localparam int unsigned SAMPLE_HZ = 1000;
  // derived cycle and sample counts
  localparam longint unsigned MODE_CYCLES = longint'(MODE_TIME_S) * CLK_HZ;
  localparam int unsigned GAP_SAMPLES = (GAP_TIME_MS * SAMPLE_HZ + 999) / 1000;
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned DEBOUNCE_SAMPLES = 4;
  // pulse counts that carry a command, and the ceiling of the count
  localparam logic [3:0] CNT_SILENT = 4'h6;
  localparam logic [3:0] CNT_LOSS = 4'h8;
  localparam logic [3:0] CNT_EXIT = 4'hA;
  localparam logic [3:0] CNT_MAX = 4'hB;

  typedef enum logic [1:0] {
    LTM_CMD_NONE,
    LTM_CMD_SILENT,
    LTM_CMD_LOSS,
    LTM_CMD_EXIT
  } ltm_cmd_t;

  typedef enum logic [1:0] {
    LTM_NORMAL,
    LTM_SILENT,
    LTM_LOSS
  } ltm_mode_t;
endpackage : ltm_pkg

// ### src/ltm_mode_timer.sv
// mode duration timer: reloads on start, pulses done at terminal count
// assumes start and stop come from logic on clk_sys
`timescale 1ns/1ps
module ltm_mode_timer #(
  parameter longint unsigned CYCLES = 64'd9375000000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic stop,
  output logic done
);
  logic [39:0] remain;
  logic running;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      remain <= 40'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= 40'(CYCLES - 64'd1);
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (remain == 40'h0) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - 40'h1;
        end
      end
    end
  end
endmodule : ltm_mode_timer

// ### src/ltm_loop_test_ctrl.sv
// loop maintenance-mode controller: trigger detection, count decode, mode state
// assumes loop_active is a raw comparator level from the line interface
`timescale 1ns/1ps

module ltm_loop_test_ctrl #(
  parameter longint unsigned MODE_LEN = ltm_pkg::MODE_CYCLES,
  parameter int unsigned TICK_DIV = ltm_pkg::SAMPLE_DIV,
  parameter int unsigned GAP_LEN = ltm_pkg::GAP_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic loop_active,
  output logic startup_allow,
  output logic tx_enable,
  output logic tx_test_signal,
  output ltm_pkg::ltm_mode_t mode,
  output logic maint_active
);
  import ltm_pkg::*;

  typedef enum logic [1:0] {
    LTM_DET_IDLE,
    LTM_DET_PULSES,
    LTM_DET_STOP
  } ltm_det_t;

  // two-stage synchroniser on the loop level
  logic sync_a;
  logic sync_b;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= loop_active;
      sync_b <= sync_a;
    end
  end

  // 1 kHz sample tick, far above 64 pulses per second
  logic [31:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (tick_cnt == 32'(TICK_DIV - 1)) begin
        tick_cnt <= 32'h0;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end

  // debounce: level must agree over several samples before it is taken
  logic [2:0] agree_cnt;
  logic level;
  logic level_prev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      agree_cnt <= 3'h0;
      level <= 1'b0;
    end else if (tick) begin
      if (sync_b == level) begin
        agree_cnt <= 3'h0;
      end else if (agree_cnt == 3'(DEBOUNCE_SAMPLES - 1)) begin
        agree_cnt <= 3'h0;
        level <= sync_b;
      end else begin
        agree_cnt <= agree_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
    end
  end

  logic edge_seen;
  assign edge_seen = level != level_prev;

  // time the level has been steady, in samples, saturating at GAP_LEN
  logic [15:0] steady_cnt;
  logic steady_long;
  assign steady_long = steady_cnt >= 16'(GAP_LEN);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      steady_cnt <= 16'h0;
    end else if (edge_seen) begin
      steady_cnt <= 16'h0;
    end else if (tick && !steady_long) begin
      steady_cnt <= steady_cnt + 16'h1;
    end
  end

  // sequence detector: a long steady level is a start interval; the idle level
  // it shows is the reference, and each return-to-idle edge (dc) or each level
  // change, leaving or returning to no-current (ac), adds one to the count, up to CNT_MAX
  ltm_det_t det;
  ltm_det_t next_det;
  logic idle_level;
  logic next_idle_level;
  logic [3:0] pulse_cnt;
  logic [3:0] next_pulse_cnt;
  logic [3:0] half_cnt;
  logic [3:0] next_half_cnt;
  logic [3:0] stop_count;
  logic [3:0] next_stop_count;
  logic cmd_valid;
  ltm_cmd_t cmd;
  logic counts_clear;
  logic at_idle_level;

  assign counts_clear = pulse_cnt == 4'h0 && half_cnt == 4'h0;
  assign at_idle_level = level == idle_level;

  always_comb begin
    next_det = det;
    next_idle_level = idle_level;
    next_pulse_cnt = pulse_cnt;
    next_half_cnt = half_cnt;
    next_stop_count = stop_count;
    case (det)
      LTM_DET_IDLE: begin
        if (steady_long) begin
          next_idle_level = level;
          next_pulse_cnt = 4'h0;
          next_half_cnt = 4'h0;
          next_det = LTM_DET_PULSES;
        end
      end
      LTM_DET_PULSES: begin
        // edge first: steady flag is still stale in the cycle the edge shows
        if (edge_seen) begin
          // dc: one break is leave and return; ac: each leave or return is a half cycle
          if (half_cnt != CNT_MAX) begin
            next_half_cnt = half_cnt + 4'h1;
          end
          if (at_idle_level && pulse_cnt != CNT_MAX) begin
            next_pulse_cnt = pulse_cnt + 4'h1;
          end
        end else if (steady_long && counts_clear) begin
          next_idle_level = level; // start interval continues, keep reference
        end else if (steady_long && at_idle_level) begin
          next_stop_count = idle_level ? pulse_cnt : half_cnt;
          next_det = LTM_DET_STOP;
        end else if (steady_long) begin
          next_det = LTM_DET_IDLE;
        end
      end
      LTM_DET_STOP: begin
        // stop interval doubles as the next start interval
        next_idle_level = level;
        next_pulse_cnt = 4'h0;
        next_half_cnt = 4'h0;
        next_det = LTM_DET_PULSES;
      end
      default: next_det = LTM_DET_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      det <= LTM_DET_IDLE;
    end else begin
      det <= next_det;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idle_level <= 1'b0;
    end else begin
      idle_level <= next_idle_level;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= 4'h0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= next_half_cnt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stop_count <= 4'h0;
    end else begin
      stop_count <= next_stop_count;
    end
  end

  // decode the finished count; other counts give no command
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= det == LTM_DET_STOP;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd <= LTM_CMD_NONE;
    end else begin
      case (stop_count)
        CNT_SILENT: cmd <= LTM_CMD_SILENT;
        CNT_LOSS: cmd <= LTM_CMD_LOSS;
        CNT_EXIT: cmd <= LTM_CMD_EXIT;
        default: cmd <= LTM_CMD_NONE;
      endcase
    end
  end

  // mode state; back to normal on the exit count, on timer expiry, or by reset, which is the power cycle
  logic timer_start;
  logic timer_stop;
  logic timer_done;
  ltm_mode_t next_mode;

  always_comb begin
    next_mode = mode;
    timer_start = 1'b0;
    timer_stop = 1'b0;
    // an invalid count must not swallow a timeout of the same cycle
    if (cmd_valid && cmd != LTM_CMD_NONE) begin
      case (cmd)
        LTM_CMD_SILENT: begin
          next_mode = LTM_SILENT;
          timer_start = 1'b1;
        end
        LTM_CMD_LOSS: begin
          next_mode = LTM_LOSS;
          timer_start = 1'b1;
        end
        LTM_CMD_EXIT: begin
          if (mode != LTM_NORMAL) begin
            next_mode = LTM_NORMAL;
            timer_stop = 1'b1;
          end
        end
        default: next_mode = mode;
      endcase
    end else if (timer_done) begin
      next_mode = LTM_NORMAL;
    end
  end

  ltm_mode_timer #(
    .CYCLES(MODE_LEN)
  ) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(timer_start),
    .stop(timer_stop),
    .done(timer_done)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode <= LTM_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      startup_allow <= 1'b1;
    end else begin
      startup_allow <= next_mode == LTM_NORMAL;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_enable <= 1'b1;
    end else begin
      tx_enable <= next_mode != LTM_SILENT;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_test_signal <= 1'b0;
    end else begin
      tx_test_signal <= next_mode == LTM_LOSS;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      maint_active <= 1'b0;
    end else begin
      maint_active <= next_mode != LTM_NORMAL;
    end
  end
endmodule : ltm_loop_test_ctrl

// ### tb/ltm_ctrl_props.sv
// port assertions for the loop test mode controller
// assumes loop_active toggles only inside trigger sequences
`timescale 1ns/1ps
module ltm_ctrl_props
  import ltm_pkg::*;
#(
  parameter longint unsigned MODE_LEN = ltm_pkg::MODE_CYCLES,
  parameter int unsigned TICK_DIV = ltm_pkg::SAMPLE_DIV,
  parameter int unsigned GAP_LEN = ltm_pkg::GAP_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic loop_active,
  input wire logic startup_allow,
  input wire logic tx_enable,
  input wire logic tx_test_signal,
  input wire ltm_pkg::ltm_mode_t mode,
  input wire logic maint_active
);
  localparam longint unsigned LAT_LO = longint'(GAP_LEN - 2) * TICK_DIV;
  localparam longint unsigned LAT_HI = longint'(GAP_LEN + 10) * TICK_DIV;
  // cycles since the loop level last moved
  longint unsigned quiet;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quiet <= '0;
    end else if ($changed(loop_active)) begin
      quiet <= '0;
    end else begin
      quiet <= quiet + 1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  silent_outputs_a: assert property (mode == LTM_SILENT |->
    !tx_enable && !startup_allow && !tx_test_signal && maint_active) else $error("silent outs");
  loss_outputs_a: assert property (mode == LTM_LOSS |->
    tx_test_signal && tx_enable && !startup_allow && maint_active) else $error("loss outs");
  normal_outputs_a: assert property (mode == LTM_NORMAL |->
    startup_allow && tx_enable && !tx_test_signal && !maint_active) else $error("normal outs");
  reset_normal_a: assert property ($rose(rstn) |-> mode == LTM_NORMAL)
    else $error("mode after reset");
  change_window_a: assert property ($changed(mode) |->
    (quiet >= LAT_LO && quiet <= LAT_HI) || quiet >= MODE_LEN) else $error("change time");
  mode_bound_a: assert property (mode != LTM_NORMAL |->
    quiet <= MODE_LEN + LAT_HI) else $error("mode overstays");
  entry_hold_a: assert property ($rose(maint_active) |=> maint_active [*8])
    else $error("mode not latched");
  outs_together_a: assert property ($changed(maint_active) || $changed(tx_test_signal)
    |-> $changed(mode)) else $error("outputs apart");
  silent_seen_c: cover property (mode == LTM_SILENT);
  loss_seen_c: cover property (mode == LTM_LOSS);
  maint_left_c: cover property ($fell(maint_active));
endmodule : ltm_ctrl_props

bind ltm_loop_test_ctrl ltm_ctrl_props #(
  .MODE_LEN(MODE_LEN), .TICK_DIV(TICK_DIV), .GAP_LEN(GAP_LEN)) props (
  .clk_sys(clk_sys), .rstn(rstn), .loop_active(loop_active), .startup_allow(startup_allow),
  .tx_enable(tx_enable), .tx_test_signal(tx_test_signal), .mode(mode),
  .maint_active(maint_active));

// ### tb/ltm_loop_tester.sv
// network test equipment model: start, pulses, stop on the loop
// assumes the bench clock; drives only on falling edges
`timescale 1ns/1ps
module ltm_loop_tester #(
  parameter int TICK = 10
) (
  input wire logic clk_sys,
  output logic loop_active
);
  initial loop_active = 1'b1;
  task automatic hold(input int ticks);
    repeat (ticks * TICK) @(negedge clk_sys);
  endtask : hold
  // dc idles with current, ac idles without
  task automatic send(input int n, input bit ac);
    int k;
    loop_active = !ac;
    hold(45);
    for (k = 0; k < n; k++) begin
      loop_active = ac ? !loop_active : 1'b0;
      hold(8);
      if (!ac) begin
        loop_active = 1'b1;
        hold(8);
      end
    end
    loop_active = !ac;
    hold(45);
  endtask : send
endmodule : ltm_loop_tester

// ### tb/nt_loop_test_mode_control_test.sv
// self-checking bench for the loop test mode controller
// assumes the tester model paces all trigger sequences
`timescale 1ns/1ps
module nt_loop_test_mode_control_test;
  import ltm_pkg::*;
  localparam logic [5:0] E_NORM = {LTM_NORMAL, 4'hC};
  localparam logic [5:0] E_SIL = {LTM_SILENT, 4'h1};
  localparam logic [5:0] E_LOSS = {LTM_LOSS, 4'h7};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic loop_active, startup_allow, tx_enable, tx_test_signal, maint_active;
  ltm_mode_t mode;
  int bad_count = 0;
  int check_count = 0;
  int dc_n[13] = '{6, 1, 5, 7, 9, 12, 8, 8, 6, 8, 10, 6, 10};
  logic [5:0] dc_e[13] = '{E_SIL, E_SIL, E_SIL, E_SIL, E_SIL, E_SIL, E_LOSS,
    E_LOSS, E_SIL, E_LOSS, E_NORM, E_SIL, E_NORM};
  int ac_n[4] = '{8, 6, 10, 10};
  logic [5:0] ac_e[4] = '{E_LOSS, E_SIL, E_NORM, E_NORM};
  initial forever #4 clk_sys = ~clk_sys;
  ltm_loop_tester #(.TICK(10)) tester (.clk_sys(clk_sys), .loop_active(loop_active));
  ltm_loop_test_ctrl #(.MODE_LEN(14000), .TICK_DIV(10), .GAP_LEN(20)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .loop_active(loop_active), .startup_allow(startup_allow),
    .tx_enable(tx_enable), .tx_test_signal(tx_test_signal), .mode(mode),
    .maint_active(maint_active));
  task automatic chk(input string what, input logic [5:0] exp);
    logic [5:0] got;
    got = {mode, startup_allow, tx_enable, tx_test_signal, maint_active};
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic t_dc;
    int i;
    chk("reset", E_NORM);
    for (i = 0; i < 13; i++) begin
      tester.send(dc_n[i], 1'b0);
      chk("dc step", dc_e[i]);
    end
    $display("t_dc done");
  endtask : t_dc
  task automatic t_ac;
    int i;
    for (i = 0; i < 4; i++) begin
      tester.send(ac_n[i], 1'b1);
      chk("ac step", ac_e[i]);
    end
    $display("t_ac done");
  endtask : t_ac
  task automatic t_timeout;
    tester.send(6, 1'b0);
    repeat (6000) @(negedge clk_sys);
    tester.send(6, 1'b0);
    repeat (8000) @(negedge clk_sys);
    chk("restarted", E_SIL);
    repeat (6500) @(negedge clk_sys);
    chk("silent end", E_NORM);
    tester.send(8, 1'b0);
    repeat (14500) @(negedge clk_sys);
    chk("loss end", E_NORM);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_power;
    tester.send(6, 1'b0);
    chk("before cycle", E_SIL);
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("power off", E_NORM);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("power on", E_NORM);
    $display("t_power done");
  endtask : t_power
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    t_dc();
    t_ac();
    t_timeout();
    t_power();
    print_verdict();
  end
  initial begin
    #800000;
    bad_count++;
    print_verdict();
  end
endmodule : nt_loop_test_mode_control_test
